// ===== pkg/emx_pkg.sv
// shared constants and types for the expansion mux bank decoder
package emx_pkg;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned BANK_W        = 3;
  localparam int unsigned CHAN_W        = 4;
  localparam int unsigned NUM_CHAN      = 16;
  localparam int unsigned ID_W          = 8;
  localparam int unsigned RESULT_W      = 12;
  localparam int unsigned BANK_LSB      = 4;
  localparam logic [2:0]  BANK_RESERVED = 3'h0;
  // arbitrary neutral values; a real board carries its own code
  localparam logic [7:0]  BOARD_ID_DEF  = 8'h05;
  localparam logic [7:0]  CONV_ID_DEF   = 8'h30;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SETTLE_RELAY_US = 8500;
  localparam int unsigned SETTLE_SS_US    = 40;
  // divide first: microseconds times 1e6 overflows a 32-bit count
  localparam int unsigned CYC_PER_US    = 1000000 / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_RELAY_CYC =
    SETTLE_RELAY_US * CYC_PER_US;
  localparam int unsigned SETTLE_SS_CYC =
    SETTLE_SS_US * CYC_PER_US;
  localparam int unsigned CNT_W = 24;
  // software register offsets of the converter end
  localparam logic [3:0] REG_CSR    = 4'h0;
  localparam logic [3:0] REG_RESULT = 4'h4;
  localparam logic [3:0] REG_MODULE = 4'h8;
  localparam int unsigned CSR_GO    = 0;
  localparam int unsigned CSR_DONE  = 1;
  localparam int unsigned CSR_PRES  = 2;
  localparam int unsigned CSR_RELAY = 3;
  localparam int unsigned CSR_CH_LSB = 8;
  typedef enum logic [1:0] {SW_SOLID, SW_RELAY_THEN_SOLID} emx_sw_mode_t;

  function automatic logic [2:0] emx_bank_of(input logic [6:0] addr);
    emx_bank_of = addr[6:4];
  endfunction : emx_bank_of
endpackage : emx_pkg

// ===== pkg/emx_cable_if.sv
// flat cable between converter and expansion mux boards
`timescale 1ns/1ps
interface emx_cable_if;
  import emx_pkg::*;
  logic [ADDR_W-1:0] channel_select_bits;
  logic              present_o;
  logic              present_oe;
  logic [ID_W-1:0]   id_o;
  logic              id_oe;
  logic              bus_switch_on;
  logic [CHAN_W-1:0] bus_channel;
  logic [RESULT_W-1:0] analog_sample;
  modport board (input channel_select_bits, output present_o,
                 output present_oe, output id_o, output id_oe,
                 output bus_switch_on, output bus_channel);
  modport conv  (output channel_select_bits, input present_o,
                 input present_oe, input id_o, input id_oe,
                 input bus_switch_on, input bus_channel,
                 input analog_sample);
endinterface : emx_cable_if

// ===== rtl/emx_bank_match.sv
// bank compare and channel one-hot decode
`timescale 1ns/1ps
module emx_bank_match
  import emx_pkg::*;
(
  input  wire logic [ADDR_W-1:0]   addr,      // channel address
  input  wire logic [BANK_W-1:0]   bank_sw,   // switch bank setting
  output logic                     hit,       // addressed
  output logic [NUM_CHAN-1:0]      onehot     // channel switch enables
);
  always_comb begin
    // bank 0 belongs to the converter, never answer there
    hit = (bank_sw != BANK_RESERVED) &&
          (emx_bank_of(addr) == bank_sw);
    onehot = '0;
    if (hit) begin
      onehot[addr[CHAN_W-1:0]] = 1'b1;
    end
  end
endmodule : emx_bank_match

// ===== rtl/emx_board.sv
// expansion mux board end
`timescale 1ns/1ps
module emx_board
  import emx_pkg::*;
#(
  parameter logic [ID_W-1:0] BOARD_ID = BOARD_ID_DEF // arbitrary
)(
  emx_cable_if.board              cab,        // cable side
  input  wire logic               core_clk,   // unused, no clock here
  input  wire logic [BANK_W-1:0]  bank_sw,    // switch setting 1..7
  input  wire logic               relay_ver,  // isolated version strap
  output logic [NUM_CHAN-1:0]     relay_on,   // relay stage per channel
  output logic [NUM_CHAN-1:0]     semi_on     // semiconductor switch
);
  import emx_pkg::*;
  logic              hit;
  logic [NUM_CHAN-1:0] onehot;

  // purely combinational: board holds no registers
  emx_bank_match u_match (
    .addr   (cab.channel_select_bits),
    .bank_sw(bank_sw),
    .hit    (hit),
    .onehot (onehot)
  );

  always_comb begin
    relay_on = relay_ver ? onehot : '0;
    semi_on  = onehot;
  end

  assign cab.bus_switch_on = hit;
  assign cab.bus_channel   = cab.channel_select_bits[CHAN_W-1:0];
  assign cab.present_o     = hit;
  assign cab.present_oe    = hit;
  assign cab.id_o          = hit ? BOARD_ID : '0;
  assign cab.id_oe         = hit;
endmodule : emx_board

// ===== rtl/emx_conv.sv
// converter end: csr, settle timing, presence and id merge
`timescale 1ns/1ps
module emx_conv
  import emx_pkg::*;
#(
  parameter int unsigned RELAY_CYC = SETTLE_RELAY_CYC, // relay settle
  parameter int unsigned SS_CYC    = SETTLE_SS_CYC     // solid settle
)(
  emx_cable_if.conv               cab,       // cable side
  input  wire logic               core_clk,  // 200 MHz clock
  input  wire logic               sys_rst,   // sync reset, high
  input  wire logic [3:0]         addr,      // register address
  input  wire logic [31:0]        wdata,     // write data
  input  wire logic               wr,        // write strobe
  input  wire logic               rd,        // read strobe
  output logic [31:0]             rdata_ff   // read data
);
  import emx_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_DONE} emx_st_t;
  emx_st_t           st_ff;
  logic [ADDR_W-1:0] ch_ff;
  logic              relay_ff, done_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [RESULT_W-1:0] result_ff;
  logic              pres_s1_ff, pres_ff;
  logic [ID_W-1:0]   id_s1_ff, id_ff;
  logic              go;

  assign cab.channel_select_bits = ch_ff;
  assign go = wr && (addr == REG_CSR) && wdata[CSR_GO];

  // presence and id lines come from another board: two flops first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pres_s1_ff <= 1'b0;
      pres_ff    <= 1'b0;
      id_s1_ff   <= '0;
      id_ff      <= '0;
    end else begin
      pres_s1_ff <= cab.present_oe & cab.present_o;
      pres_ff    <= pres_s1_ff;
      id_s1_ff   <= cab.id_oe ? cab.id_o : '0;
      id_ff      <= id_s1_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ch_ff    <= '0;
      relay_ff <= 1'b0;
    end else if (wr && addr == REG_CSR) begin
      ch_ff    <= wdata[CSR_CH_LSB +: ADDR_W];
      relay_ff <= wdata[CSR_RELAY];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff     <= ST_IDLE;
      cnt_ff    <= '0;
      done_ff   <= 1'b0;
      result_ff <= '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (go) begin
            done_ff <= 1'b0;
            cnt_ff  <= wdata[CSR_RELAY] ? CNT_W'(RELAY_CYC) :
                       CNT_W'(SS_CYC);
            st_ff   <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (cnt_ff <= CNT_W'(1)) begin
            st_ff <= ST_DONE;
          end else begin
            cnt_ff <= cnt_ff - CNT_W'(1);
          end
        end
        ST_DONE: begin
          result_ff <= cab.analog_sample;
          done_ff   <= 1'b1;
          st_ff     <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (rd) begin
      case (addr)
        REG_CSR: begin
          rdata_ff <= {17'h0, ch_ff, 4'h0, relay_ff, pres_ff, done_ff,
                       st_ff != ST_IDLE};
        end
        REG_RESULT: rdata_ff <= {20'h0, result_ff};
        REG_MODULE: rdata_ff <= {24'h0, CONV_ID_DEF | id_ff};
        default:    rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end
endmodule : emx_conv

// ===== tb/emx_checker.sv
// cable assertions between converter and board
`timescale 1ns/1ps
module emx_checker
  import emx_pkg::*;
#(
  parameter logic [ID_W-1:0] BOARD_ID = BOARD_ID_DEF // id
)(
  input wire logic              core_clk,            // clk
  input wire logic              sys_rst,             // rst
  input wire logic [ADDR_W-1:0] channel_select_bits, // addr
  input wire logic              present_o,           // pres
  input wire logic              present_oe,          // pres en
  input wire logic [ID_W-1:0]   id_o,                // id
  input wire logic              id_oe,               // id en
  input wire logic              bus_switch_on,       // closed
  input wire logic [CHAN_W-1:0] bus_channel          // chan
);
  import emx_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic [2:0] bank    = channel_select_bits[6:4];
  wire logic [3:0] bank_lo = channel_select_bits[3:0];
  // a hit must hold while the bank field stays put
  sequence s_hit; present_oe ##1 $stable(bank); endsequence
  sequence s_miss; !present_oe ##1 $stable(bank); endsequence
  property p_bank0; bank == BANK_RESERVED |-> !present_oe; endproperty
  a_bank0: assert property (p_bank0) else $error("bank0 pres");
  property p_open; bank == 3'h0 |-> !bus_switch_on && !id_oe; endproperty
  a_open: assert property (p_open) else $error("bank0 open");
  property p_chan; bus_switch_on |-> bus_channel == bank_lo; endproperty
  a_chan: assert property (p_chan) else $error("bad chan");
  property p_pres; present_oe |-> present_o; endproperty
  a_pres: assert property (p_pres) else $error("pres low");
  property p_id; id_oe |-> id_o == BOARD_ID; endproperty
  a_id: assert property (p_id) else $error("bad id");
  property p_one; present_oe == id_oe && id_oe == bus_switch_on; endproperty
  a_one: assert property (p_one) else $error("drive split");
  property p_keep; s_hit |-> present_oe; endproperty
  a_keep: assert property (p_keep) else $error("hit lost");
  property p_idle; s_miss |-> !present_oe && !bus_switch_on; endproperty
  a_idle: assert property (p_idle) else $error("miss drove");
endmodule : emx_checker

// ===== tb/emx_tb_top.sv
// converter and one board joined by the cable
`timescale 1ns/1ps
module emx_tb_top;
  import emx_pkg::*;
  logic        core_clk, sys_rst, wr, rd, relay_ver;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata_ff, r;
  logic [2:0]  bank_sw;
  logic [15:0] relay_on, semi_on;
  logic [11:0] smp;
  int          bad_count, n_tests;
  emx_cable_if cab();
  assign cab.analog_sample = smp;
  emx_board emx_board_i(.cab, .core_clk, .bank_sw, .relay_ver, .relay_on,
    .semi_on);
  emx_conv #(.RELAY_CYC(5), .SS_CYC(5)) emx_conv_i(.cab, .core_clk,
    .sys_rst, .addr, .wdata, .wr, .rd, .rdata_ff);
  emx_checker emx_checker_i(.core_clk, .sys_rst, .id_o(cab.id_o),
    .channel_select_bits(cab.channel_select_bits), .id_oe(cab.id_oe),
    .present_o(cab.present_o), .present_oe(cab.present_oe),
    .bus_switch_on(cab.bus_switch_on), .bus_channel(cab.bus_channel));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic conclude;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    r = rdata_ff;
  endtask : rd_reg
  // switch only moves under reset, so the board never sees a live change
  task automatic sc_sweep(input logic [2:0] sw);
    logic [3:0]  lo;
    logic [15:0] oh;
    logic        hit;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    bank_sw <= sw;
    relay_ver <= sw[0];
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int b = 0; b < 8; b++) begin
      // bank zero belongs to the converter, a board set there stays mute
      hit = (3'(b) == sw) && (sw != 3'h0);
      lo = 4'(b * 2 + sw);
      oh = hit ? 16'h1 << lo : 16'h0;
      smp <= {1'b0, 3'(b), lo, 4'hA};
      wr_reg(REG_CSR, {17'h0, 3'(b), lo, 4'h0, sw[0], 3'h1});
      repeat (40) begin
        rd_reg(REG_CSR);
        if (r[CSR_DONE] === 1'b1) break;
      end
      chk(r[CSR_DONE], 1);
      chk(r[CSR_PRES], hit);
      chk(cab.channel_select_bits, {3'(b), lo});
      chk(semi_on, oh);
      chk(relay_on, sw[0] ? oh : 16'h0);
      rd_reg(REG_MODULE);
      chk(r[7:0], CONV_ID_DEF | (hit ? BOARD_ID_DEF : 8'h0));
      rd_reg(REG_RESULT);
      chk(r[11:0], smp);
    end
    rd_reg(4'hC);
    chk(r, 0);
  endtask : sc_sweep
  initial begin
    {sys_rst, wr, rd, addr, wdata, smp, bad_count, n_tests} = '0;
    sys_rst = 1'b1;
    bank_sw = 3'h1;
    relay_ver = 1'b1;
    for (int s = 0; s < 8; s++) sc_sweep(3'(s));
    conclude();
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule : emx_tb_top
